// ### hw/pm_device.sv
// Device end: power state, transceiver reset, wake cause and indicator pin
`timescale 1ns/1ps
module pm_device
  import pm_pkg::*;
#(
  parameter int pulse_cycles = pm_pkg::pulse_cycles_def
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host bus
  pm_bus_if.device bus,
  // Event sources and transceiver
  input wire logic lan_wake_event,
  input wire logic energy_event,
  output logic transceiver_reset_n,
  output logic wake_interrupt,
  output logic [1:0] power_state_select
);
  import pm_pkg::*;

  // Control register fields
  logic [1:0] state_q;
  logic [1:0] state_d;
  logic lan_en_q;
  logic energy_detect_enable_q;
  logic buf_type_q;
  logic pulse_sel_q;
  logic polarity_q;
  logic pin_en_q;
  logic [1:0] cause_q;
  logic [1:0] cause_d;
  logic [31:0] rdata_q;
  // Transceiver reset timer
  logic xrst_q;
  logic [cnt_w-1:0] xrst_cnt_q;
  // Settle timer and write gate
  logic ready_q;
  logic read_seen_q;
  logic [cnt_w-1:0] settle_cnt_q;
  // Indicator pulse
  logic [1:0] hit_q;
  logic active_q;
  logic [cnt_w-1:0] pulse_cnt_q;

  // Address decode and write qualification
  wire sel_ctrl = bus.addr == power_control_off;
  wire sel_test = bus.addr == byte_test_off;
  wire reduced = state_q != state_normal;
  wire wr_ok = bus.wr && ready_q && read_seen_q;
  wire ctrl_wr = wr_ok && sel_ctrl && !reduced;
  wire wake_wr = bus.wr && sel_test && reduced;
  wire [1:0] state_wr = bus.wdata[state_lsb+1:state_lsb];
  wire state_wr_legal = state_wr != state_reserved;
  wire xrst_wr = ctrl_wr && bus.wdata[xrst_bit];
  wire xrst_done = xrst_q && xrst_cnt_q == cnt_w'(xrst_cycles - 1);

  // Wake events
  wire lan_hit = lan_wake_event && lan_en_q;
  wire ed_hit = energy_event && energy_detect_enable_q;
  wire [1:0] cause_set = {lan_hit, ed_hit};
  wire [1:0] src_live = {lan_wake_event, energy_event};
  wire cause_event = lan_hit || ed_hit;
  wire wake_event = reduced && cause_event;
  wire [1:0] hit_rise = cause_set & ~hit_q;
  wire clr_ok = ctrl_wr && ready_q && !reduced;
  wire [1:0] clr_mask = bus.wdata[cause_lsb+1:cause_lsb];

  // Waking wins over a write in the same cycle
  assign state_d = (wake_wr || wake_event) ? state_normal :
    (ctrl_wr && state_wr_legal) ? state_wr : state_q;
  wire state_change = state_d != state_q;

  // A cause bit clears on a one only once its source is gone; a set wins
  for (genvar b = 0; b < 2; b++) begin : g_cause
    wire clr_bit = clr_ok && clr_mask[b] && !src_live[b];
    assign cause_d[b] = cause_set[b] || (cause_q[b] && !clr_bit);
  end

  wire [31:0] ctrl_word = {18'h0, state_q, 1'b0, xrst_q, lan_en_q, energy_detect_enable_q, 1'b0, buf_type_q, cause_q,
    pulse_sel_q, polarity_q, pin_en_q, ready_q};
  // Only this register is decoded here; any other offset reads zero
  wire [31:0] rd_word = sel_ctrl ? ctrl_word : 32'h0;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= state_normal;
      cause_q <= 2'h0;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lan_en_q <= 1'b0;
      energy_detect_enable_q <= 1'b0;
      buf_type_q <= 1'b0;
      pulse_sel_q <= 1'b0;
      polarity_q <= 1'b0;
      pin_en_q <= 1'b0;
    end else if (ctrl_wr) begin
      lan_en_q <= bus.wdata[lan_en_bit];
      energy_detect_enable_q <= bus.wdata[energy_detect_enable_bit];
      buf_type_q <= bus.wdata[buf_type_bit];
      pulse_sel_q <= bus.wdata[pulse_sel_bit];
      polarity_q <= bus.wdata[polarity_bit];
      pin_en_q <= bus.wdata[pin_en_bit];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xrst_q <= 1'b0;
    end else if (xrst_done) begin
      xrst_q <= 1'b0;
    end else if (xrst_wr && !xrst_q) begin
      xrst_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xrst_cnt_q <= '0;
    end else if (xrst_q) begin
      xrst_cnt_q <= xrst_cnt_q + 1'b1;
    end else begin
      xrst_cnt_q <= '0;
    end
  end

  // Ready drops on every entry to or exit from reduced power, then settles
  wire settle_done = !ready_q && settle_cnt_q == cnt_w'(settle_cycles - 1);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt_q <= '0;
    end else if (state_change) begin
      settle_cnt_q <= '0;
    end else if (!ready_q) begin
      settle_cnt_q <= settle_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_q <= 1'b0;
    end else if (state_change) begin
      ready_q <= 1'b0;
    end else if (settle_done) begin
      ready_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_seen_q <= 1'b0;
    end else if (state_change) begin
      read_seen_q <= 1'b0;
    end else if (ready_q && bus.rd) begin
      read_seen_q <= 1'b1;
    end
  end

  // Indicator fires on a new event, so a source left high cannot stretch a pulse
  wire pin_event = pin_en_q && |hit_rise;
  wire pin_drop = !pin_en_q || cause_q == 2'h0;
  wire pulse_end = active_q && pulse_sel_q && pulse_cnt_q == cnt_w'(pulse_cycles - 1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) hit_q <= 2'h0;
    else hit_q <= cause_set;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      active_q <= 1'b0;
    end else if (pin_event) begin
      active_q <= 1'b1;
    end else if (pin_drop || pulse_end) begin
      active_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_cnt_q <= '0;
    end else if (active_q && pulse_sel_q && !pin_event) begin
      pulse_cnt_q <= pulse_cnt_q + 1'b1;
    end else begin
      pulse_cnt_q <= '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rd_word;
    end
  end

  assign bus.rdata = rdata_q;
  // Open-drain only pulls low, so polarity has no say there
  wire pp_level = polarity_q ? active_q : !active_q;
  assign bus.wake_indicator_pin_o = buf_type_q ? pp_level : 1'b0;
  assign bus.wake_indicator_pin_oe = buf_type_q || active_q;
  assign wake_interrupt = cause_q != 2'h0;
  assign transceiver_reset_n = !xrst_q;
  assign power_state_select = state_q;
endmodule // pm_device

// ### hw/pm_pkg.sv
// Constants and types shared by the power-management control ends
// Overview of operation
// - Control register readable in every power state
// - Writes ignored until first read after wake
// - State field: 00 normal, 01 frame, 10 energy
// - Test register write wakes reduced power state
// - Host writes only test register while unready
// - Transceiver reset held 100us, then self-clears
// - Writes to reset bit ignored while high
// - LAN wake event drives pin if enabled
// - LAN wake event raises interrupt regardless pin
// - Energy event drives pin if enabled
// - Energy event raises interrupt regardless pin
// - Buffer type: clear open-drain, set push-pull
// - Open-drain ignores polarity, always active low
// - Cause field: none, energy, frame, multiple
// - Write one clears cause bit, zero ignored
// - Cause clears only in normal state, ready
// - Cause clears only once event sources cleared
// - Pulse mode 50ms, else level until cleared
// - Push-pull polarity bit selects active level
// - Ready flag after settle; others invalid before
package pm_pkg;
  localparam logic [7:0] power_control_off = 8'h84;
  localparam logic [7:0] byte_test_off = 8'h64;
  localparam int state_lsb = 12;
  localparam int xrst_bit = 10;
  localparam int lan_en_bit = 9;
  localparam int energy_detect_enable_bit = 8;
  localparam int buf_type_bit = 6;
  localparam int cause_lsb = 4;
  localparam int pulse_sel_bit = 3;
  localparam int polarity_bit = 2;
  localparam int pin_en_bit = 1;
  localparam int ready_bit = 0;
  localparam logic [1:0] state_normal = 2'h0;
  localparam logic [1:0] state_frame = 2'h1;
  localparam logic [1:0] state_energy = 2'h2;
  localparam logic [1:0] state_reserved = 2'h3;
  localparam int clk_mhz = 40;
  localparam int xrst_time_us = 100;
  localparam int pulse_time_ms = 50;
  localparam int settle_time_us = 2;
  localparam int xrst_cycles = xrst_time_us * clk_mhz;
  localparam int pulse_cycles_def = pulse_time_ms * 1000 * clk_mhz;
  localparam int settle_cycles = settle_time_us * clk_mhz;
  localparam int cnt_w = 22;
  typedef enum logic [2:0] {
    hs_idle = 3'b001,
    hs_rd = 3'b010,
    hs_wr = 3'b100
  } host_state_t;
endpackage

// ### hw/pm_bus_if.sv
// Host register bus and wake indicator pin between host and device
`timescale 1ns/1ps
interface pm_bus_if;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic rd;
  logic wr;
  logic wake_indicator_pin_o;
  logic wake_indicator_pin_oe;
  logic wake_indicator_pin_i;
  modport device (input addr, input wdata, input rd, input wr, input wake_indicator_pin_i,
    output rdata, output wake_indicator_pin_o, output wake_indicator_pin_oe);
  modport host (output addr, output wdata, output rd, output wr, input rdata, input wake_indicator_pin_i);
endinterface

// ### hw/pm_host.sv
// Host end: simple command port turned into bus reads and writes
`timescale 1ns/1ps
module pm_host
  import pm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus to device
  pm_bus_if.host bus,
  // User command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic device_ready
);
  import pm_pkg::*;

  host_state_t st_q;
  logic [7:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rsp_q;
  logic rsp_v_q;
  logic rdy_q;
  logic read_done_q;
  logic cap_q;

  // Writes other than the wake register wait for ready and a prior read
  wire wr_allowed = (cmd_addr == byte_test_off) || (rdy_q && read_done_q);
  assign cmd_ready = (st_q == hs_idle) && !cap_q && (!cmd_write || wr_allowed);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= hs_idle;
      addr_q <= 8'h0;
      wdata_q <= 32'h0;
      rsp_q <= 32'h0;
      rsp_v_q <= 1'b0;
      rdy_q <= 1'b0;
      read_done_q <= 1'b0;
      cap_q <= 1'b0;
    end else begin
      rsp_v_q <= 1'b0;
      cap_q <= 1'b0;
      // Read data is registered behind the address, so take it one cycle after the strobe
      if (cap_q) begin
        rsp_q <= bus.rdata;
        rsp_v_q <= 1'b1;
        if (addr_q == power_control_off) begin
          rdy_q <= bus.rdata[ready_bit];
          read_done_q <= bus.rdata[ready_bit];
        end
      end
      unique case (st_q)
        hs_idle: begin
          if (cmd_valid && cmd_ready) begin
            addr_q <= cmd_addr;
            wdata_q <= cmd_wdata;
            st_q <= cmd_write ? hs_wr : hs_rd;
            if (cmd_write && cmd_addr == byte_test_off) begin
              rdy_q <= 1'b0;
              read_done_q <= 1'b0;
            end
          end
        end
        hs_rd: begin
          cap_q <= 1'b1;
          st_q <= hs_idle;
        end
        hs_wr: begin
          if (addr_q == power_control_off && wdata_q[state_lsb+1:state_lsb] != state_normal) begin
            rdy_q <= 1'b0;
            read_done_q <= 1'b0;
          end
          st_q <= hs_idle;
        end
      endcase
    end
  end

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.rd = st_q == hs_rd;
  assign bus.wr = st_q == hs_wr;
  assign rsp_valid = rsp_v_q;
  assign rsp_rdata = rsp_q;
  assign device_ready = rdy_q;
endmodule // pm_host

// ### tb/pm_bus_sva.sv
// Checker for the host bus and wake indicator pin
`timescale 1ns/1ps
module pm_bus_sva
  import pm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus and pin
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic rd,
  input wire logic wr,
  input wire logic wake_indicator_pin_o,
  input wire logic wake_indicator_pin_oe,
  input wire logic wake_indicator_pin_i
);
  logic seen_rd_q, rdy_q;
  logic [7:0] up_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {seen_rd_q, rdy_q, up_q} <= '0;
    end else begin
      seen_rd_q <= seen_rd_q | rd;
      up_q <= up_q + {7'h0, up_q != 8'hff};
      if ($past(rd) && $past(addr) == power_control_off) rdy_q <= rdata[ready_bit];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Read data lags the address by one cycle
  sequence s_ctrl;
    $past(rd) && $past(addr) == power_control_off;
  endsequence
  a_state_legal:
    assert property (s_ctrl |-> rdata[13:12] != state_reserved) else $error("reserved state read");
  a_other_reads_zero:
    assert property ($past(rd) && $past(addr) != power_control_off |-> rdata == 32'h0) else $error("bad read");
  a_ready_settles:
    assert property (s_ctrl ##0 up_q < 8'd79 |-> !rdata[ready_bit]) else $error("ready too early");
  a_read_first:
    assert property (wr |-> seen_rd_q) else $error("write before read");
  a_unready_write:
    assert property (wr && !rdy_q |-> addr == byte_test_off) else $error("write while unready");
  a_od_active_low:
    assert property (s_ctrl ##0 !rdata[buf_type_bit] && wake_indicator_pin_oe |-> !wake_indicator_pin_o)
      else $error("open drain drove high");
  a_pp_drives:
    assert property (s_ctrl ##0 rdata[buf_type_bit] && rdata[pin_en_bit] |-> wake_indicator_pin_oe)
      else $error("push pull not driving");
  a_pp_idle_level:
    assert property (s_ctrl ##0 rdata[buf_type_bit] && rdata[5:4] == 2'h0 |->
      wake_indicator_pin_o == !rdata[polarity_bit]) else $error("idle level wrong");
  a_pin_released:
    assert property (!$past(reset_n) |-> !wake_indicator_pin_oe) else $error("pin driven at reset");
endmodule // pm_bus_sva

// ### tb/power_mgmt_wake_control_tb_top.sv
// Testbench joining the host and device ends
`timescale 1ns/1ps
module power_mgmt_wake_control_tb_top;
  import pm_pkg::*;
  localparam int pulse_len = 100;
  logic clk, reset_n, lan_ev, en_ev, cmd_valid, cmd_write, cmd_ready, rsp_valid, device_ready, xrst_n, irq;
  logic [7:0] cmd_addr;
  logic [31:0] cmd_wdata, rsp_rdata, rdat;
  logic [1:0] pss;
  int num_errors = 0;
  int tests_run = 0;
  pm_bus_if bus ();
  // Pull-up on the indicator wire
  assign bus.wake_indicator_pin_i = bus.wake_indicator_pin_oe ? bus.wake_indicator_pin_o : 1'b1;
  pm_device #(.pulse_cycles(pulse_len)) i_pm_device (.clk(clk), .reset_n(reset_n), .bus(bus),
    .lan_wake_event(lan_ev), .energy_event(en_ev), .transceiver_reset_n(xrst_n), .wake_interrupt(irq),
    .power_state_select(pss));
  pm_host i_pm_host (.clk(clk), .reset_n(reset_n), .bus(bus), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .device_ready(device_ready));
  pm_bus_sva i_pm_bus_sva (.clk(clk), .reset_n(reset_n), .addr(bus.addr), .wdata(bus.wdata),
    .rdata(bus.rdata), .rd(bus.rd), .wr(bus.wr), .wake_indicator_pin_o(bus.wake_indicator_pin_o),
    .wake_indicator_pin_oe(bus.wake_indicator_pin_oe), .wake_indicator_pin_i(bus.wake_indicator_pin_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Three negedges after acceptance also keep the two-cycle command spacing
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    rdat = 'x;
    @(negedge clk);
    {cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, w, a, d};
    for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge clk);
    if (cmd_ready !== 1'b1) num_errors++;
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 3; n++) begin
      if (rsp_valid === 1'b1) rdat = rsp_rdata;
      @(negedge clk);
    end
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 60; n++) begin
      op(1'b0, power_control_off, 32'h0);
      if (rdat[ready_bit] === 1'b1) break;
    end
  endtask
  task automatic t_reset();
    op(1'b0, power_control_off, 32'h0);
    check(rdat, 32'h0);
    wait_ready();
    check(rdat, 32'h1);
    check(device_ready, 1'b1);
    check({xrst_n, irq, pss}, 4'h8);
    op(1'b0, 8'h80, 32'h0);
    check(rdat, 32'h0);
  endtask
  task automatic t_xrst();
    op(1'b1, power_control_off, 32'h400);
    op(1'b1, power_control_off, 32'h0);
    op(1'b0, power_control_off, 32'h0);
    check({rdat[xrst_bit], xrst_n}, 2'b10);
    repeat (xrst_cycles - 100) @(negedge clk);
    check(xrst_n, 1'b0);
    repeat (200) @(negedge clk);
    op(1'b0, power_control_off, 32'h0);
    check({rdat[xrst_bit], xrst_n}, 2'b01);
  endtask
  task automatic t_wake(input logic [1:0] st, input logic lan, ed, pp, pol, pulse);
    logic [31:0] ctrl;
    logic act;
    ctrl = 32'h302 | {pp, 2'b0, pulse, pol, 2'b0};
    act = pp ? pol : 1'b0;
    op(1'b1, power_control_off, ctrl | {18'h0, st, 12'h0});
    check(pss, st);
    {lan_ev, en_ev} = {lan, ed};
    repeat (10) @(negedge clk);
    check({irq, bus.wake_indicator_pin_i}, {1'b1, act});
    wait_ready();
    check({pss, rdat[5:4]}, {state_normal, lan, ed});
    op(1'b1, power_control_off, ctrl | 32'h30);
    if (pulse) repeat (pulse_len) @(negedge clk);
    op(1'b0, power_control_off, 32'h0);
    check(rdat[5:4], {lan, ed});
    check(bus.wake_indicator_pin_i, pulse ? !act : act);
    {lan_ev, en_ev} = 2'b00;
    op(1'b1, power_control_off, ctrl | 32'h30);
    op(1'b0, power_control_off, 32'h0);
    check({rdat[5:4], irq, bus.wake_indicator_pin_i}, {3'b000, !act});
  endtask
  task automatic t_test_wake();
    op(1'b1, power_control_off, {18'h0, state_reserved, 12'h0});
    op(1'b0, power_control_off, 32'h0);
    check({pss, rdat[13:12]}, 4'h0);
    op(1'b1, power_control_off, {18'h0, state_energy, 12'h0});
    op(1'b0, power_control_off, 32'h0);
    check(rdat[13:12], state_energy);
    op(1'b1, byte_test_off, 32'h0);
    wait_ready();
    check({pss, rdat[5:4], rdat[ready_bit]}, 5'h01);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {reset_n, lan_ev, en_ev, cmd_valid, cmd_write, cmd_addr, cmd_wdata} = '0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_xrst();
    t_wake(state_frame, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    t_wake(state_energy, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    t_wake(state_frame, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    t_test_wake();
    stop_test();
  end
  initial begin
    #500000;
    num_errors++;
    stop_test();
  end
endmodule // power_mgmt_wake_control_tb_top
